// ==== src/kms_pkg.sv ====
// Purpose: Shared constants and carriers for the keyboard matrix scanner.
// Assumes: 10 MHz mclk, synchronous active-high reset.
// Notes:   Byte offsets are the printed register offsets.

package kms_pkg;

    // ==========================================================
    // Sizes
    localparam int KMS_ROWS = 18;
    localparam int KMS_COLS = 8;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] KMS_OFF_ROW_CTRL = 8'h04;
    localparam logic [7:0] KMS_OFF_PIN_STATE = 8'h08;
    localparam logic [7:0] KMS_OFF_EDGE_FLAGS = 8'h0C;
    localparam logic [7:0] KMS_OFF_IRQ_EN = 8'h10;
    localparam logic [7:0] KMS_OFF_EXT_CTRL = 8'h14;

    // ==========================================================
    // Field positions
    localparam int KMS_POS_POLARITY = 7;
    localparam int KMS_POS_DISABLE = 6;
    localparam int KMS_POS_ALL_ROWS = 5;
    localparam int KMS_POS_INDEX_LSB = 0;
    localparam int KMS_POS_BOOST = 0;
    localparam logic [4:0] KMS_ROW_INDEX_LAST = 5'h11;

    // ==========================================================
    // Reset values
    localparam logic [7:0] KMS_RST_ROW_CTRL = 8'h40;
    localparam logic [7:0] KMS_RST_COLUMNS = 8'h00;
    localparam logic [7:0] KMS_RST_FLAGS = 8'h00;
    localparam logic [7:0] KMS_RST_IRQ_EN = 8'h00;
    localparam logic KMS_RST_BOOST = 1'b0;

    // ==========================================================
    // Timing: predrive covers two cycles of the 48 MHz clock, rounded up to whole mclk cycles
    localparam int KMS_MCLK_KHZ = 10000;
    localparam int KMS_FAST_KHZ = 48000;
    localparam int KMS_PREDRIVE_FAST_CYC = 2;
    localparam int KMS_PREDRIVE_RAW =
        (KMS_PREDRIVE_FAST_CYC * KMS_MCLK_KHZ + KMS_FAST_KHZ - 1) / KMS_FAST_KHZ;
    localparam logic [1:0] KMS_PREDRIVE_CYC =
        2'(KMS_PREDRIVE_RAW < 1 ? 1 : KMS_PREDRIVE_RAW);

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic       row_drive_polarity;
        logic       scan_disable;
        logic       all_rows_drive;
        logic [4:0] row_index;
    } kms_ctrl_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic       wr;
        logic       rd;
    } kms_bus_s;

    typedef struct packed {
        kms_ctrl_s             ctrl;
        logic                  high_boost_on;
        logic [KMS_COLS-1:0]   column_irq_mask;
        logic [KMS_COLS-1:0]   column_fall_flags;
        logic [KMS_COLS-1:0]   sync1;
        logic [KMS_COLS-1:0]   sync2;
        logic [KMS_COLS-1:0]   sync3;
        logic [KMS_COLS-1:0]   col_state;
        logic [KMS_ROWS-1:0]   row_level;
        logic [KMS_ROWS-1:0]   row_oe;
        logic                  was_disabled;
        logic [1:0]            boost_cnt;
        logic                  irq;
        logic                  hold_off;
        logic                  low_power;
        logic                  sleep_inhibit;
        logic [31:0]           rdata;
    } kms_state_s;

    localparam kms_state_s KMS_STATE_RST = '{
        ctrl:              kms_ctrl_s'(KMS_RST_ROW_CTRL),
        high_boost_on:     KMS_RST_BOOST,
        column_irq_mask:   KMS_RST_IRQ_EN,
        column_fall_flags: KMS_RST_FLAGS,
        sync1:             KMS_RST_COLUMNS,
        sync2:             KMS_RST_COLUMNS,
        sync3:             KMS_RST_COLUMNS,
        col_state:         KMS_RST_COLUMNS,
        row_level:         {KMS_ROWS{1'b1}},
        was_disabled:      1'b1,
        low_power:         1'b1,
        default:           '0
    };

endpackage : kms_pkg

// ==== src/kms_scanner.sv ====
// Purpose: Register-driven scanner for an 18 row by 8 column key matrix.
// Assumes: Row pin buffer type (push-pull or open-drain) is set outside.
// Notes:   Column pins are filtered by a three-flop synchroniser.
//
// What this block does
// - Scan disabled turns every row output enable off, overriding all else.
// - Scan disable comes out of reset set, rows off.
// - Polarity 0, single row index 0..17: that row low, others high.
// - Polarity 1, single row index: that row high, others low.
// - Index 18..31 selects none: all rows at the inactive level of polarity.
// - All-rows drive ignores index: all high for polarity 0, low for 1.
// - Column state read returns present column levels; writes ignored.
// - A column falling edge sets its sticky fall flag.
// - Writing 1 clears a fall flag; writing 0 leaves it.
// - Flag and mask per column, ORed into one interrupt.
// - Interrupt is an active-high level, drops when no column contributes.
// - After assertion, no new assertion until all columns return high.
// - Edge detection and interrupt intended to wake the chip from sleep.
// - Block sits in low power when not scanning or when disabled.
// - Sleep held off only while scanning is active.
// - With boost on, rows going high are driven for predrive time first.
// - One clock; system reset returns all state to defaults.
//
// The address-and-strobe port was decided locally.

`timescale 1ns/1ps
`default_nettype none

module kms_scanner
    import kms_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic                reset,
    input  wire logic [7:0]          bus_addr,
    input  wire logic [31:0]         bus_wdata,
    input  wire logic                bus_wr,
    input  wire logic                bus_rd,
    output var  logic [31:0]         bus_rdata,
    input  wire logic [KMS_COLS-1:0] matrix_column_in,
    output var  logic [KMS_ROWS-1:0] matrix_row_out,
    output var  logic [KMS_ROWS-1:0] matrix_row_out_oe,
    output var  logic                matrix_irq,
    output var  logic                low_power,
    output var  logic                sleep_inhibit
);

    // ==========================================================
    // State
    kms_state_s          st_reg;
    kms_state_s          st_next;
    kms_bus_s            bus;
    logic [KMS_COLS-1:0] fall;
    logic [KMS_COLS-1:0] wr_clear;
    logic [KMS_ROWS-1:0] pattern;
    logic                no_single_row;
    logic                pattern_change;
    logic                pending;
    logic                all_high;

    assign bus = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

    // ==========================================================
    // Next-state logic
    always_comb begin
        st_next = st_reg;

        // Three flops; a level counts once the last two agree
        st_next.sync1 = matrix_column_in;
        st_next.sync2 = st_reg.sync1;
        st_next.sync3 = st_reg.sync2;
        if (st_reg.sync2 == st_reg.sync3) begin
            st_next.col_state = st_reg.sync3;
        end

        // Falling edge on the filtered level; needs mclk running
        fall = st_reg.col_state & ~st_next.col_state;

        // Register writes
        wr_clear = '0;
        if (bus.wr) begin
            if (bus.addr == KMS_OFF_ROW_CTRL) begin
                st_next.ctrl = kms_ctrl_s'(bus.wdata[7:0]);
            end else if (bus.addr == KMS_OFF_EXT_CTRL) begin
                st_next.high_boost_on = bus.wdata[KMS_POS_BOOST];
            end else if (bus.addr == KMS_OFF_IRQ_EN) begin
                st_next.column_irq_mask = bus.wdata[7:0];
            end else if (bus.addr == KMS_OFF_EDGE_FLAGS) begin
                wr_clear = bus.wdata[7:0];
            end
        end

        // A new edge beats a clear in the same cycle
        st_next.column_fall_flags = (st_reg.column_fall_flags & ~wr_clear) | fall;

        // Row pattern from the current control
        no_single_row = st_reg.ctrl.all_rows_drive
                      || (st_reg.ctrl.row_index > KMS_ROW_INDEX_LAST);
        pattern = {KMS_ROWS{~st_reg.ctrl.row_drive_polarity}};
        if (no_single_row) begin
            pattern = {KMS_ROWS{~st_reg.ctrl.row_drive_polarity}};
        end else begin
            pattern[st_reg.ctrl.row_index] = st_reg.ctrl.row_drive_polarity;
        end
        st_next.row_level = pattern;

        // Any change, or leaving disable, restarts the predrive window
        st_next.was_disabled = st_reg.ctrl.scan_disable;
        pattern_change = (pattern != st_reg.row_level)
                       || (st_reg.was_disabled && !st_reg.ctrl.scan_disable);
        if (pattern_change) begin
            st_next.boost_cnt = KMS_PREDRIVE_CYC;
        end else if (st_reg.boost_cnt != 2'h0) begin
            st_next.boost_cnt = st_reg.boost_cnt - 2'h1;
        end

        // Output enables; low rows stay driven, high rows release after boost
        if (st_reg.ctrl.scan_disable) begin
            st_next.row_oe = '0;
        end else if (st_reg.high_boost_on) begin
            st_next.row_oe = ~pattern | {KMS_ROWS{st_next.boost_cnt != 2'h0}};
        end else begin
            st_next.row_oe = '1;
        end

        // Interrupt with re-arm hold-off until every column is high
        pending  = |(st_reg.column_fall_flags & st_reg.column_irq_mask);
        all_high = &st_reg.col_state;
        st_next.irq = pending && (st_reg.irq || !st_reg.hold_off);
        if (st_next.irq && !st_reg.irq) begin
            st_next.hold_off = 1'b1;
        end else if (all_high) begin
            st_next.hold_off = 1'b0;
        end

        // Low power whenever no single row is being scanned
        st_next.low_power     = st_reg.ctrl.scan_disable || no_single_row;
        st_next.sleep_inhibit = !(st_reg.ctrl.scan_disable || no_single_row);

        // Read data stands in the cycle after the strobe only
        st_next.rdata = '0;
        if (bus.rd) begin
            if (bus.addr == KMS_OFF_ROW_CTRL) begin
                st_next.rdata = {24'h000000, st_reg.ctrl};
            end else if (bus.addr == KMS_OFF_PIN_STATE) begin
                st_next.rdata = {24'h000000, st_reg.col_state};
            end else if (bus.addr == KMS_OFF_EDGE_FLAGS) begin
                st_next.rdata = {24'h000000, st_reg.column_fall_flags};
            end else if (bus.addr == KMS_OFF_IRQ_EN) begin
                st_next.rdata = {24'h000000, st_reg.column_irq_mask};
            end else if (bus.addr == KMS_OFF_EXT_CTRL) begin
                st_next.rdata = {31'h00000000, st_reg.high_boost_on};
            end
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge mclk) begin
        if (reset) begin
            st_reg <= KMS_STATE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // Outputs, all straight from flops
    assign bus_rdata         = st_reg.rdata;
    assign matrix_row_out    = st_reg.row_level;
    assign matrix_row_out_oe = st_reg.row_oe;
    assign matrix_irq        = st_reg.irq;
    assign low_power         = st_reg.low_power;
    assign sleep_inhibit     = st_reg.sleep_inhibit;

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    a_disable_rows_off: assert property (
        st_reg.ctrl.scan_disable |=> (matrix_row_out_oe == '0))
        else $error("rows enabled while scan disabled");

    a_reset_disabled_state: assert property (
        $past(reset) |-> (st_reg.ctrl.scan_disable && matrix_row_out_oe == '0))
        else $error("scanner not disabled after reset");

    a_single_row_low: assert property (
        (!st_reg.ctrl.all_rows_drive && !st_reg.ctrl.row_drive_polarity
         && st_reg.ctrl.row_index <= KMS_ROW_INDEX_LAST)
        |=> (matrix_row_out == ~(18'h00001 << $past(st_reg.ctrl.row_index))))
        else $error("selected row not the only low row");

    a_single_row_high: assert property (
        (!st_reg.ctrl.all_rows_drive && st_reg.ctrl.row_drive_polarity
         && st_reg.ctrl.row_index <= KMS_ROW_INDEX_LAST)
        |=> (matrix_row_out == (18'h00001 << $past(st_reg.ctrl.row_index))))
        else $error("selected row not the only high row");

    a_no_row_select: assert property (
        (st_reg.ctrl.all_rows_drive || st_reg.ctrl.row_index > KMS_ROW_INDEX_LAST)
        |=> (matrix_row_out == {KMS_ROWS{~$past(st_reg.ctrl.row_drive_polarity)}}))
        else $error("rows not uniform with no single row");

    a_column_read_back: assert property (
        (bus_rd && bus_addr == KMS_OFF_PIN_STATE)
        |=> (bus_rdata == {24'h000000, $past(st_reg.col_state)}))
        else $error("column read does not match filtered pins");

    a_fall_sets_flag: assert property (
        (fall != '0) |=> ((st_reg.column_fall_flags & $past(fall)) == $past(fall)))
        else $error("falling edge did not set its flag");

    a_flag_clear_write: assert property (
        (bus_wr && bus_addr == KMS_OFF_EDGE_FLAGS && fall == '0)
        |=> (st_reg.column_fall_flags == ($past(st_reg.column_fall_flags) & ~$past(bus_wdata[7:0]))))
        else $error("flag write did not clear exactly the ones");

    a_irq_needs_source: assert property (
        !pending |=> !matrix_irq)
        else $error("interrupt without flagged and enabled column");

    a_irq_rearm_hold: assert property (
        (st_reg.hold_off && !matrix_irq && !all_high) |=> !matrix_irq)
        else $error("interrupt re-asserted before columns went high");

    a_sleep_matches_power: assert property (
        (st_reg.ctrl.scan_disable || st_reg.ctrl.all_rows_drive
         || st_reg.ctrl.row_index > KMS_ROW_INDEX_LAST)
        |=> (low_power && !sleep_inhibit))
        else $error("sleep held off while not scanning");

    a_predrive_release: assert property (
        (st_reg.high_boost_on && !st_reg.ctrl.scan_disable && !pattern_change
         && st_reg.boost_cnt == 2'h0)
        ##1 (!pattern_change && st_reg.high_boost_on && !st_reg.ctrl.scan_disable)
        |=> (matrix_row_out_oe == ~matrix_row_out))
        else $error("high rows still driven after predrive");

endmodule : kms_scanner

`default_nettype wire

// ==== test/kms_matrix_model.sv ====
// Purpose: Key switch matrix seen from the scanner's row and column pins.
// Assumes: Rows and columns carry pull-ups; a pressed key joins row and column.
// Notes:   Columns follow the rows with no delay; the scanner filters them.

`timescale 1ns/1ps
`default_nettype none

module kms_matrix_model
    import kms_pkg::*;
(
    input  wire logic [KMS_ROWS-1:0]               row_out,
    input  wire logic [KMS_ROWS-1:0]               row_oe,
    input  wire logic [KMS_ROWS-1:0][KMS_COLS-1:0] pressed,
    output var  logic [KMS_COLS-1:0]               column
);
    // ==========================================================
    // Wire levels
    logic [KMS_ROWS-1:0] row_wire;

    always_comb begin
        row_wire = row_out | ~row_oe; // Released rows float up to the pull-up
        column = '1;
        for (int r = 0; r < KMS_ROWS; r++) begin
            if (!row_wire[r]) begin
                column = column & ~pressed[r]; // A low row pulls its pressed columns low
            end
        end
    end
endmodule : kms_matrix_model

`default_nettype wire

// ==== test/tb_top.sv ====
// Purpose: Self-checking bench for the keyboard matrix scanner.
// Assumes: 10 MHz mclk, synchronous reset held 8 cycles.
// Notes:   Waits of a few cycles cover the three-flop column filter.

`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
    $display("[ERR] %0t got %h expected %h", $time, a, b); end end

module tb_top;
    import kms_pkg::*;

    // ==========================================================
    // Signals
    logic                               mclk;
    logic                               reset;
    logic [7:0]                         bus_addr;
    logic [31:0]                        bus_wdata;
    logic                               bus_wr;
    logic                               bus_rd;
    logic [31:0]                        bus_rdata;
    logic [KMS_COLS-1:0]                column;
    logic [KMS_ROWS-1:0]                row_out;
    logic [KMS_ROWS-1:0]                row_oe;
    logic                               matrix_irq;
    logic                               low_power;
    logic                               sleep_inhibit;
    logic [KMS_ROWS-1:0][KMS_COLS-1:0]  pressed;
    logic [31:0]                        d;
    logic [7:0]                         c;
    int                                 miscompares = 0;
    int                                 num_checks = 0;
    int                                 cycles = 0;
    logic [7:0] corner [10] = '{8'h00, 8'h11, 8'h12, 8'h1F, 8'h91, 8'h92, 8'hA5, 8'h25,
                                8'h40, 8'hFF};

    kms_scanner kms_scanner_inst (.mclk(mclk), .reset(reset), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .matrix_column_in(column), .matrix_row_out(row_out), .matrix_row_out_oe(row_oe),
        .matrix_irq(matrix_irq), .low_power(low_power), .sleep_inhibit(sleep_inhibit));

    kms_matrix_model kms_matrix_model_inst (.row_out(row_out), .row_oe(row_oe),
        .pressed(pressed), .column(column));

    // ==========================================================
    // Clock, timeout and verdict
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic wrap_up();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    // Whole run needs well under 2000 cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            wrap_up();
        end
    end

    // ==========================================================
    // Bus tasks and reference model
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        bus_addr <= a;
        bus_wdata <= v;
        bus_wr <= 1'b1;
        @(posedge mclk);
        bus_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge mclk);
        bus_rd <= 1'b0;
        #1 v = bus_rdata;
    endtask : rd

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : settle

    // Row levels for an enabled scan; index above 17 selects nothing
    function automatic logic [KMS_ROWS-1:0] exp_rows(input logic [7:0] k);
        logic [KMS_ROWS-1:0] r;
        r = (k[5] || k[4:0] > 5'd17) ? '1 : ~(18'h1 << k[4:0]);
        return k[7] ? ~r : r;
    endfunction : exp_rows

    // ==========================================================
    // Main sequence
    initial begin
        reset = 1'b1;
        bus_addr = 8'h00;
        bus_wdata = '0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        pressed = '0;
        d = $urandom(6);
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        settle(6);
        `CHK(row_oe, 18'h0)
        `CHK({matrix_irq, low_power, sleep_inhibit}, 3'b010)
        foreach (corner[i]) begin
            if (i < 6) begin
                rd(8'(4 * i), d);
                `CHK(d, (i == 1) ? 32'h40 : (i == 2) ? 32'hFF : 32'h0)
            end
        end
        for (int i = 0; i < 22; i++) begin
            c = (i < 10) ? corner[i] : 8'($urandom());
            wr(KMS_OFF_ROW_CTRL, {24'hFFFFFF, c});
            settle(2);
            `CHK(row_oe, c[6] ? 18'h0 : 18'h3FFFF)
            if (!c[6]) `CHK(row_out, exp_rows(c))
            `CHK(low_power, c[6] | c[5] | (c[4:0] > 5'd17))
            `CHK(sleep_inhibit, ~(c[6] | c[5] | (c[4:0] > 5'd17)))
            rd(KMS_OFF_ROW_CTRL, d);
            `CHK(d, {24'h0, c})
        end
        // Key at row 3 column 2, scanned with row 3 low
        wr(KMS_OFF_IRQ_EN, 32'h24);
        wr(KMS_OFF_ROW_CTRL, 32'h03);
        pressed[3][2] <= 1'b1;
        settle(8);
        wr(KMS_OFF_PIN_STATE, 32'h0);
        rd(KMS_OFF_PIN_STATE, d);
        `CHK(d, 32'hFB)
        rd(KMS_OFF_EDGE_FLAGS, d);
        `CHK(d, 32'h04)
        `CHK(matrix_irq, 1'b1)
        wr(KMS_OFF_EDGE_FLAGS, 32'hFB);
        rd(KMS_OFF_EDGE_FLAGS, d);
        `CHK(d, 32'h04)
        wr(KMS_OFF_EDGE_FLAGS, 32'h04);
        settle(2);
        `CHK(matrix_irq, 1'b0)
        // Second key while the first is held: no new interrupt yet
        pressed[3][5] <= 1'b1;
        settle(8);
        rd(KMS_OFF_EDGE_FLAGS, d);
        `CHK(d, 32'h20)
        `CHK(matrix_irq, 1'b0)
        wr(KMS_OFF_EDGE_FLAGS, 32'h20);
        pressed <= '0;
        settle(8);
        pressed[3][2] <= 1'b1;
        settle(8);
        `CHK(matrix_irq, 1'b1)
        wr(KMS_OFF_IRQ_EN, 32'h00);
        settle(2);
        `CHK(matrix_irq, 1'b0)
        pressed <= '0;
        // Predrive: all rows driven one cycle, then only low rows stay driven
        wr(KMS_OFF_ROW_CTRL, 32'h40);
        wr(KMS_OFF_EXT_CTRL, 32'h1);
        wr(KMS_OFF_ROW_CTRL, 32'h05);
        settle(1);
        `CHK(row_oe, 18'h3FFFF)
        settle(3);
        `CHK(row_oe, ~exp_rows(8'h05))
        wr(KMS_OFF_ROW_CTRL, 32'h40);
        wr(KMS_OFF_EXT_CTRL, 32'h0);
        rd(KMS_OFF_EXT_CTRL, d);
        `CHK(d, 32'h0)
        wrap_up();
    end
endmodule : tb_top

`undef CHK
`default_nettype wire
